/* File: hdl/mas_alu_ops.v */
// Purpose : execution datapath for rotates, subtracts, skips, bit set, table reads, xor
// Assumes : data memory answers a read on the cycle after dm_rd_o, program memory likewise
// Notes   : accumulator, flags and table pointer are also reachable over AHB-Lite
`timescale 1ns/1ps
`include "mas_alu_regs.vh"

module mas_alu_ops (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  input  wire        op_start_i,
  input  wire [4:0]  op_code_i,
  input  wire [6:0]  op_addr_i,
  input  wire [2:0]  op_bit_i,
  input  wire [7:0]  op_imm_i,
  input  wire [2:0]  pc_page_i,
  output reg         op_busy_o,
  output reg         op_done_o,
  output reg         skip_o,
  output reg         dm_rd_o,
  output reg         dm_wr_o,
  output reg  [6:0]  dm_addr_o,
  output reg  [7:0]  dm_wdata_o,
  input  wire [7:0]  dm_rdata_i,
  output reg         pm_rd_o,
  output reg  [10:0] pm_addr_o,
  input  wire [13:0] pm_rdata_i,
  output reg  [7:0]  acc_o,
  output reg  [3:0]  flags_o
);

  // ======================================================================
  // sequencer states
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_EXEC  = 2'h2;
  localparam [1:0] ST_DUMMY = 2'h3;

  reg  [1:0] state;
  reg  [4:0] op;
  reg  [2:0] op_bit;
  reg  [7:0] op_imm;
  reg  [7:0] table_pointer_reg;
  reg  [5:0] table_high_byte_latch;
  reg        last_skip;
  reg        wr_pend;
  reg  [7:0] wr_addr;
  wire [7:0] bit_mask;

  // ======================================================================
  // decode helpers

  // table reads take their operand from program memory
  function is_table;
    input [4:0] code;
    begin
      is_table = (code == `MAS_OP_TABLE_READ_CURRENT_PAGE) ||
                 (code == `MAS_OP_TABLE_READ_LAST_PAGE);
    end
  endfunction

  // literal ops and whole-byte set need no data memory read
  function needs_dm;
    input [4:0] code;
    begin
      needs_dm = !is_table(code) &&
                 (code != `MAS_OP_MINUS_IMM_TO_A) &&
                 (code != `MAS_OP_EXCLUSIVE_OR_IMM_TO_A) &&
                 (code != `MAS_OP_SET_ALL_MEM);
    end
  endfunction

  // a - b - !cin, packed as {wrap, half, carry, result}
  function [10:0] sub_fn;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [4:0] lo;
    reg   [8:0] full;
    begin
      lo     = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      full   = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      sub_fn = {(a[7] ^ b[7]) & (a[7] ^ full[7]), lo[4], full[8], full[7:0]};
    end
  endfunction

  // register read decode, unmapped words read as zero
  function [31:0] reg_read;
    input [31:0] addr;
    begin
      reg_read = 32'h0000_0000;
      if (addr[31:8] == 24'h00_0000) begin
        case (addr[7:0])
          `MAS_ADDR_ACC:      reg_read = {24'h00_0000, acc_o};
          `MAS_ADDR_FLAGS:    reg_read = {28'h000_0000, flags_o};
          `MAS_ADDR_TBL_PTR:  reg_read = {24'h00_0000, table_pointer_reg};
          `MAS_ADDR_TBL_HIGH: reg_read = {26'h000_0000, table_high_byte_latch};
          `MAS_ADDR_OP_STAT:  reg_read = {30'h0000_0000, last_skip, op_busy_o};
          default:            reg_read = 32'h0000_0000;
        endcase
      end
    end
  endfunction

  // ======================================================================
  // one-hot mask for the selected bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      localparam [2:0] IDX = gi;
      assign bit_mask[gi] = (op_bit == IDX);
    end
  endgenerate

  // ======================================================================
  // combinational execute
  reg  [7:0]  next_res;
  reg         next_to_acc;
  reg         next_to_mem;
  reg  [3:0]  next_flags;
  reg         next_skip;
  reg  [5:0]  next_tbl_high;
  reg  [10:0] sub_out;
  wire [7:0]  mem_val = dm_rdata_i;
  wire        carry   = flags_o[`MAS_FLAG_C];
  wire [7:0]  dec_val = mem_val - 8'h01;
  wire [7:0]  inc_val = mem_val + 8'h01;

  // result, destination, flags and skip decision for the latched op
  always @* begin
    next_res      = mem_val;
    next_to_acc   = 1'b0;
    next_to_mem   = 1'b0;
    next_flags    = flags_o;
    next_skip     = 1'b0;
    next_tbl_high = table_high_byte_latch;
    sub_out       = 11'h000;
    case (op)
      `MAS_OP_ROT_LEFT_THRU_CARRY_MEM, `MAS_OP_ROT_LEFT_THRU_CARRY_TO_A: begin
        next_res                = {mem_val[6:0], carry};
        next_flags[`MAS_FLAG_C] = mem_val[7];
        next_to_mem             = (op == `MAS_OP_ROT_LEFT_THRU_CARRY_MEM);
        next_to_acc             = !next_to_mem;
      end
      `MAS_OP_ROTATE_RIGHT_MEM, `MAS_OP_ROTATE_RIGHT_TO_A: begin
        next_res    = {mem_val[0], mem_val[7:1]};
        next_to_mem = (op == `MAS_OP_ROTATE_RIGHT_MEM);
        next_to_acc = !next_to_mem;
      end
      `MAS_OP_ROT_RIGHT_THRU_CARRY_MEM, `MAS_OP_ROT_RIGHT_THRU_CARRY_TO_A: begin
        next_res                = {carry, mem_val[7:1]};
        next_flags[`MAS_FLAG_C] = mem_val[0];
        next_to_mem             = (op == `MAS_OP_ROT_RIGHT_THRU_CARRY_MEM);
        next_to_acc             = !next_to_mem;
      end
      `MAS_OP_MINUS_BORROW_TO_A, `MAS_OP_MINUS_BORROW_TO_MEM,
      `MAS_OP_MINUS_TO_A, `MAS_OP_MINUS_TO_MEM, `MAS_OP_MINUS_IMM_TO_A: begin
        // plain subtract forces the carry-in, borrow form uses the flag
        if (op == `MAS_OP_MINUS_IMM_TO_A)
          sub_out = sub_fn(acc_o, op_imm, 1'b1);
        else if ((op == `MAS_OP_MINUS_BORROW_TO_A) || (op == `MAS_OP_MINUS_BORROW_TO_MEM))
          sub_out = sub_fn(acc_o, mem_val, carry);
        else
          sub_out = sub_fn(acc_o, mem_val, 1'b1);
        next_res                 = sub_out[7:0];
        next_flags[`MAS_FLAG_C]    = sub_out[8];
        next_flags[`MAS_FLAG_HALF] = sub_out[9];
        next_flags[`MAS_FLAG_WRAP] = sub_out[10];
        next_flags[`MAS_FLAG_Z]    = (sub_out[7:0] == 8'h00);
        next_to_mem = (op == `MAS_OP_MINUS_BORROW_TO_MEM) || (op == `MAS_OP_MINUS_TO_MEM);
        next_to_acc = !next_to_mem;
      end
      `MAS_OP_DEC_SKIP_IF_ZERO, `MAS_OP_DEC_SKIP_ZERO_TO_A: begin
        next_res    = dec_val;
        next_skip   = (dec_val == 8'h00);
        next_to_mem = (op == `MAS_OP_DEC_SKIP_IF_ZERO);
        next_to_acc = !next_to_mem;
      end
      `MAS_OP_INC_SKIP_IF_ZERO, `MAS_OP_INC_SKIP_ZERO_TO_A: begin
        next_res    = inc_val;
        next_skip   = (inc_val == 8'h00);
        next_to_mem = (op == `MAS_OP_INC_SKIP_IF_ZERO);
        next_to_acc = !next_to_mem;
      end
      `MAS_OP_SET_ALL_MEM: begin
        next_res    = `MAS_ALL_ONES;
        next_to_mem = 1'b1;
      end
      `MAS_OP_SET_BIT_MEM: begin
        next_res    = mem_val | bit_mask;
        next_to_mem = 1'b1;
      end
      `MAS_OP_SKIP_BIT_SET: begin
        next_skip = ((mem_val & bit_mask) != 8'h00);
      end
      `MAS_OP_SKIP_BIT_CLEAR: begin
        next_skip = ((mem_val & bit_mask) == 8'h00);
      end
      `MAS_OP_NIBBLE_EXCHANGE_MEM, `MAS_OP_NIBBLE_EXCHANGE_TO_A: begin
        next_res    = {mem_val[3:0], mem_val[7:4]};
        next_to_mem = (op == `MAS_OP_NIBBLE_EXCHANGE_MEM);
        next_to_acc = !next_to_mem;
      end
      `MAS_OP_SKIP_ON_ZERO_MEM: begin
        next_skip = (mem_val == 8'h00);
      end
      `MAS_OP_SKIP_ZERO_COPY_TO_A: begin
        next_to_acc = 1'b1;
        next_skip   = (mem_val == 8'h00);
      end
      `MAS_OP_TABLE_READ_CURRENT_PAGE, `MAS_OP_TABLE_READ_LAST_PAGE: begin
        next_res      = pm_rdata_i[7:0];
        next_tbl_high = pm_rdata_i[13:8];
        next_to_mem   = 1'b1;
      end
      `MAS_OP_EXCLUSIVE_OR_TO_A, `MAS_OP_EXCLUSIVE_OR_TO_MEM, `MAS_OP_EXCLUSIVE_OR_IMM_TO_A: begin
        if (op == `MAS_OP_EXCLUSIVE_OR_IMM_TO_A)
          next_res = acc_o ^ op_imm;
        else
          next_res = acc_o ^ mem_val;
        next_flags[`MAS_FLAG_Z] = (next_res == 8'h00);
        next_to_mem = (op == `MAS_OP_EXCLUSIVE_OR_TO_MEM);
        next_to_acc = !next_to_mem;
      end
      default: begin
        next_res = mem_val;
      end
    endcase
  end

  // ======================================================================
  // AHB-Lite slave: zero wait, always OKAY, write data taken in data phase
  wire accept = hsel_i && htrans_i[1] && hready_i;

  // address phase capture and registered read data
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend     <= accept && hwrite_i && (haddr_i[31:8] == 24'h00_0000);
      wr_addr     <= haddr_i[7:0];
      if (accept && !hwrite_i)
        hrdata_o <= reg_read(haddr_i);
      else
        hrdata_o <= 32'h0000_0000;
    end
  end

  // ======================================================================
  // sequencer, architectural state and memory strobes
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state                 <= ST_IDLE;
      op                    <= 5'h00;
      op_bit                <= 3'h0;
      op_imm                <= 8'h00;
      op_busy_o             <= 1'b0;
      op_done_o             <= 1'b0;
      skip_o                <= 1'b0;
      dm_rd_o               <= 1'b0;
      dm_wr_o               <= 1'b0;
      dm_addr_o             <= 7'h00;
      dm_wdata_o            <= 8'h00;
      pm_rd_o               <= 1'b0;
      pm_addr_o             <= 11'h000;
      acc_o                 <= `MAS_RST_ACC;
      flags_o               <= `MAS_RST_FLAGS;
      table_pointer_reg     <= `MAS_RST_TBL_PTR;
      table_high_byte_latch <= `MAS_RST_TBL_HIGH;
      last_skip             <= 1'b0;
    end else begin
      op_done_o <= 1'b0;
      skip_o    <= 1'b0;
      dm_wr_o   <= 1'b0;
      dm_rd_o   <= 1'b0;
      pm_rd_o   <= 1'b0;
      // software writes; in ST_EXEC the op overrides the flags below, and acc when it writes acc, never the table pointer
      if (wr_pend) begin
        case (wr_addr)
          `MAS_ADDR_ACC:     acc_o             <= hwdata_i[7:0];
          `MAS_ADDR_FLAGS:   flags_o           <= hwdata_i[3:0];
          `MAS_ADDR_TBL_PTR: table_pointer_reg <= hwdata_i[7:0];
          default:           acc_o             <= acc_o;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (op_start_i) begin
            op        <= op_code_i;
            op_bit    <= op_bit_i;
            op_imm    <= op_imm_i;
            dm_addr_o <= op_addr_i;
            dm_rd_o   <= needs_dm(op_code_i);
            pm_rd_o   <= is_table(op_code_i);
            if (op_code_i == `MAS_OP_TABLE_READ_LAST_PAGE)
              pm_addr_o <= {`MAS_LAST_PAGE, table_pointer_reg};
            else
              pm_addr_o <= {pc_page_i, table_pointer_reg};
            op_busy_o <= 1'b1;
            state     <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          dm_wr_o               <= next_to_mem;
          dm_wdata_o            <= next_res;
          table_high_byte_latch <= next_tbl_high;
          flags_o               <= next_flags;
          last_skip             <= next_skip;
          if (next_to_acc)
            acc_o <= next_res;
          if (next_skip) begin
            skip_o <= 1'b1;
            state  <= ST_DUMMY;
          end else begin
            op_done_o <= 1'b1;
            op_busy_o <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        ST_DUMMY: begin
          op_done_o <= 1'b1;
          op_busy_o <= 1'b0;
          state     <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // mas_alu_ops

/* File: common/mas_alu_regs.vh */
// Purpose : constants for the rotate, subtract, skip, table-read and xor execution unit
// Assumes : byte-wide data memory, 14-bit program words, 8 pages of 256 words
// Notes   : register offsets are byte addresses on the AHB-Lite slave
`ifndef MAS_ALU_REGS_VH
`define MAS_ALU_REGS_VH

// ======================================================================
// register map (byte offsets)
`define MAS_ADDR_ACC        8'h00
`define MAS_ADDR_FLAGS      8'h04
`define MAS_ADDR_TBL_PTR    8'h08
`define MAS_ADDR_TBL_HIGH   8'h0C
`define MAS_ADDR_OP_STAT    8'h10

// ======================================================================
// flag field positions
`define MAS_FLAG_C          0
`define MAS_FLAG_HALF       1
`define MAS_FLAG_Z          2
`define MAS_FLAG_WRAP       3
// operation status field positions
`define MAS_STAT_BUSY       0
`define MAS_STAT_SKIP       1

// ======================================================================
// reset values and fixed constants
`define MAS_RST_ACC         8'h00
`define MAS_RST_FLAGS       4'h0
`define MAS_RST_TBL_PTR     8'h00
`define MAS_RST_TBL_HIGH    6'h00
`define MAS_LAST_PAGE       3'h7
`define MAS_ALL_ONES        8'hFF

// ======================================================================
// operation codes
`define MAS_OP_ROT_LEFT_THRU_CARRY_MEM    5'h00
`define MAS_OP_ROT_LEFT_THRU_CARRY_TO_A   5'h01
`define MAS_OP_ROTATE_RIGHT_MEM           5'h02
`define MAS_OP_ROTATE_RIGHT_TO_A          5'h03
`define MAS_OP_ROT_RIGHT_THRU_CARRY_MEM   5'h04
`define MAS_OP_ROT_RIGHT_THRU_CARRY_TO_A  5'h05
`define MAS_OP_MINUS_BORROW_TO_A          5'h06
`define MAS_OP_MINUS_BORROW_TO_MEM        5'h07
`define MAS_OP_DEC_SKIP_IF_ZERO           5'h08
`define MAS_OP_DEC_SKIP_ZERO_TO_A         5'h09
`define MAS_OP_INC_SKIP_IF_ZERO           5'h0A
`define MAS_OP_INC_SKIP_ZERO_TO_A         5'h0B
`define MAS_OP_SET_ALL_MEM                5'h0C
`define MAS_OP_SET_BIT_MEM                5'h0D
`define MAS_OP_SKIP_BIT_SET               5'h0E
`define MAS_OP_MINUS_TO_A                 5'h0F
`define MAS_OP_MINUS_TO_MEM               5'h10
`define MAS_OP_MINUS_IMM_TO_A             5'h11
`define MAS_OP_NIBBLE_EXCHANGE_MEM        5'h12
`define MAS_OP_NIBBLE_EXCHANGE_TO_A       5'h13
`define MAS_OP_SKIP_ON_ZERO_MEM           5'h14
`define MAS_OP_SKIP_ZERO_COPY_TO_A        5'h15
`define MAS_OP_SKIP_BIT_CLEAR             5'h16
`define MAS_OP_TABLE_READ_CURRENT_PAGE    5'h17
`define MAS_OP_TABLE_READ_LAST_PAGE       5'h18
`define MAS_OP_EXCLUSIVE_OR_TO_A          5'h19
`define MAS_OP_EXCLUSIVE_OR_TO_MEM        5'h1A
`define MAS_OP_EXCLUSIVE_OR_IMM_TO_A      5'h1B

`endif

/* File: testbench/mas_alu_ops_asserts.sv */
// Purpose: concurrent checks on the operation port of the execution unit
// Assumes: one clock, asynchronous active-high reset
// Notes: op code and flags are captured at the take edge
`timescale 1ns/1ps

// ==========================================================
// checker
module mas_alu_ops_asserts (
  input wire       sys_clk_i,
  input wire       sys_rst_i,
  input wire       op_start_i,
  input wire [4:0] op_code_i,
  input wire       op_busy_o,
  input wire       op_done_o,
  input wire       skip_o,
  input wire       dm_rd_o,
  input wire       dm_wr_o,
  input wire [7:0] dm_wdata_o,
  input wire       pm_rd_o,
  input wire [3:0] flags_o
);
  logic [4:0] cap_code;
  logic [3:0] cap_flg;
  wire        take = op_start_i & ~op_busy_o;
  // hold the running op and the flags it started from
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_code <= 5'h1F;
      cap_flg  <= 4'h0;
    end else if (take) begin
      cap_code <= op_code_i;
      cap_flg  <= flags_o;
    end
  end
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_END: assert property (take |=> op_busy_o ##2 (op_done_o ^ skip_o))
    else $error("op did not end on time");
  AST_SKIP_DONE: assert property (skip_o |=> op_done_o && !skip_o && !op_busy_o)
    else $error("no done after skip");
  AST_DONE_SRC: assert property (op_done_o |-> $past(skip_o) || $past(take, 3))
    else $error("done without cause");
  AST_WR_TIME: assert property (dm_wr_o |-> (op_done_o || skip_o) && $past(take, 3))
    else $error("write at wrong cycle");
  AST_RD_TIME: assert property ((dm_rd_o || pm_rd_o) |-> $past(take))
    else $error("read not right after take");
  AST_SET_ALL: assert property (dm_wr_o && cap_code == 5'h0C |-> dm_wdata_o == 8'hFF)
    else $error("set-all data wrong");
  AST_NO_WR: assert property (dm_wr_o |-> !(cap_code inside
    {5'h01, 5'h03, 5'h05, 5'h06, 5'h09, 5'h0B, 5'h0E, 5'h0F, 5'h11, 5'h13, 5'h14, 5'h15,
     5'h16, 5'h19, 5'h1B})) else $error("memory written by accumulator or test op");
  AST_FLG_KEPT: assert property (op_done_o && (cap_code inside
    {[5'h08:5'h0E], 5'h02, 5'h03, [5'h12:5'h18]}) |-> flags_o == cap_flg)
    else $error("flags changed");
  AST_XOR_Z: assert property (op_done_o && (cap_code inside {[5'h19:5'h1B]})
    |-> {flags_o[3], flags_o[1:0]} == {cap_flg[3], cap_flg[1:0]}) else $error("xor flags");
  AST_DEC_ZERO: assert property (skip_o && (cap_code inside {5'h08, 5'h0A})
    |-> dm_wr_o && dm_wdata_o == 8'h00) else $error("skip without zero result");
  cover property (skip_o);
  cover property (dm_wr_o && op_done_o);
  cover property (pm_rd_o);
endmodule // mas_alu_ops_asserts

bind mas_alu_ops mas_alu_ops_asserts CHK (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .op_start_i(op_start_i), .op_code_i(op_code_i), .op_busy_o(op_busy_o), .op_done_o(op_done_o),
  .skip_o(skip_o), .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o), .dm_wdata_o(dm_wdata_o),
  .pm_rd_o(pm_rd_o), .flags_o(flags_o));

/* File: testbench/mas_mem_model.sv */
// Purpose: data and program memory beside the execution unit
// Assumes: synchronous read one cycle after the strobe
// Notes: unread outputs invert each cycle so stale data shows
`timescale 1ns/1ps

// ==========================================================
// memories
module mas_mem_model (
  input  wire         sys_clk_i,
  input  wire         dm_rd_i,
  input  wire         dm_wr_i,
  input  wire  [6:0]  dm_addr_i,
  input  wire  [7:0]  dm_wdata_i,
  output logic [7:0]  dm_rdata_o,
  input  wire         pm_rd_i,
  input  wire  [10:0] pm_addr_i,
  output logic [13:0] pm_rdata_o
);
  logic [7:0] mem [128];
  // program word: page twice in the high part, inverted pointer low
  always @(posedge sys_clk_i) begin
    dm_rdata_o <= dm_rd_i ? mem[dm_addr_i] : ~dm_rdata_o;
    pm_rdata_o <= pm_rd_i ? {pm_addr_i[10:8], pm_addr_i[10:8], ~pm_addr_i[7:0]} : ~pm_rdata_o;
    if (dm_wr_i)
      mem[dm_addr_i] <= dm_wdata_i;
  end
  // defined start levels
  initial begin
    dm_rdata_o = 8'h00;
    pm_rdata_o = 14'h0000;
  end
endmodule // mas_mem_model

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the execution unit
// Assumes: memories modelled beside it, registers over AHB-Lite
// Notes: each run primes registers and memory, then starts one op
`timescale 1ns/1ps

// ==========================================================
// bench
module tb_top;
  logic        clk, rst, hsel, hwrite, hrdy, hresp, ost, busy, done, skip, dmrd, dmwr, pmrd;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [4:0]  code;
  logic [6:0]  oad, dma;
  logic [2:0]  obit, page;
  logic [7:0]  imm, dmwd, dmrdat, acc;
  logic [10:0] pma;
  logic [13:0] pmrdat;
  logic [3:0]  flg;
  int          miscompares, compares, skipped;

  mas_alu_ops DUT (.sys_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .op_start_i(ost),
    .op_code_i(code), .op_addr_i(oad), .op_bit_i(obit), .op_imm_i(imm), .pc_page_i(page),
    .op_busy_o(busy), .op_done_o(done), .skip_o(skip), .dm_rd_o(dmrd), .dm_wr_o(dmwr),
    .dm_addr_o(dma), .dm_wdata_o(dmwd), .dm_rdata_i(dmrdat), .pm_rd_o(pmrd), .pm_addr_o(pma),
    .pm_rdata_i(pmrdat), .acc_o(acc), .flags_o(flg));
  mas_mem_model M (.sys_clk_i(clk), .dm_rd_i(dmrd), .dm_wr_i(dmwr), .dm_addr_i(dma),
    .dm_wdata_i(dmwd), .dm_rdata_o(dmrdat), .pm_rd_i(pmrd), .pm_addr_i(pma),
    .pm_rdata_o(pmrdat));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one single-word transfer: address phase, then data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
    chk(hresp, 32'h0);
  endtask
  function automatic logic [11:0] sub_exp(input logic [7:0] a, b, input logic ci);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, a} + {1'b0, ~b} + ci;
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + ci;
    return {(a[7] ^ b[7]) & (a[7] ^ r[7]), r[7:0] == 8'h00, h[4], r[8], r[7:0]};
  endfunction
  // prime acc, flags and memory, run one op, judge all results
  task run(input logic [4:0] c, input logic [7:0] x, m, a0, input logic [3:0] f0,
           input logic [7:0] em, ea, input logic [3:0] ef, input int en);
    int n;
    wr(8'h00, {24'h0, a0});
    wr(8'h04, {28'h0, f0});
    M.mem[{2'h1, c}] = m;
    @(posedge clk);
    ost <= 1'b1;
    code <= c;
    oad <= {2'h1, c};
    obit <= x[2:0];
    imm <= x;
    @(posedge clk);
    ost <= 1'b0;
    n = 0;
    skipped = 0;
    do begin
      @(negedge clk);
      n++;
      if (skip === 1'b1)
        skipped = 1;
    end while (done !== 1'b1 && n < 9);
    @(negedge clk);
    chk(n, en);
    chk(skipped, en == 4);
    chk(M.mem[{2'h1, c}], em);
    chk(acc, ea);
    chk(flg, ef);
  endtask

  task t_regs;
    rdc(8'h0C, 32'h0);
    wr(8'h0C, 32'hFF);
    rdc(8'h0C, 32'h0);
    rdc(8'h14, 32'h0);
  endtask
  task t_rot;
    run(5'h00, 8'h0, 8'hB5, 8'h00, 4'hE, 8'h6A, 8'h00, 4'hF, 3);
    run(5'h00, 8'h0, 8'h35, 8'h00, 4'h1, 8'h6B, 8'h00, 4'h0, 3);
    run(5'h01, 8'h0, 8'hB5, 8'h00, 4'hE, 8'hB5, 8'h6A, 4'hF, 3);
    run(5'h02, 8'h0, 8'hB5, 8'h00, 4'hE, 8'hDA, 8'h00, 4'hE, 3);
    run(5'h03, 8'h0, 8'hB5, 8'h00, 4'hE, 8'hB5, 8'hDA, 4'hE, 3);
    run(5'h04, 8'h0, 8'hB5, 8'h00, 4'hE, 8'h5A, 8'h00, 4'hF, 3);
    run(5'h05, 8'h0, 8'hB5, 8'h00, 4'hE, 8'hB5, 8'h5A, 4'hF, 3);
  endtask
  task t_sub;
    logic [11:0] e;
    e = sub_exp(8'h80, 8'h01, 1'b0);
    run(5'h06, 8'h0, 8'h01, 8'h80, 4'h0, 8'h01, e[7:0], e[11:8], 3);
    run(5'h07, 8'h0, 8'h01, 8'h80, 4'h0, e[7:0], 8'h80, e[11:8], 3);
    e = sub_exp(8'h42, 8'h42, 1'b1);
    run(5'h0F, 8'h0, 8'h42, 8'h42, 4'h0, 8'h42, e[7:0], e[11:8], 3);
    e = sub_exp(8'h10, 8'h21, 1'b1);
    run(5'h10, 8'h0, 8'h21, 8'h10, 4'hF, e[7:0], 8'h10, e[11:8], 3);
    e = sub_exp(8'h80, 8'h7F, 1'b1);
    run(5'h11, 8'h7F, 8'h00, 8'h80, 4'h0, 8'h00, e[7:0], e[11:8], 3);
  endtask
  task t_skip;
    run(5'h08, 8'h0, 8'h01, 8'hAA, 4'h5, 8'h00, 8'hAA, 4'h5, 4);
    run(5'h09, 8'h0, 8'h01, 8'hAA, 4'h5, 8'h01, 8'h00, 4'h5, 4);
    run(5'h0A, 8'h0, 8'hFF, 8'hAA, 4'h5, 8'h00, 8'hAA, 4'h5, 4);
    run(5'h0B, 8'h0, 8'h7F, 8'hAA, 4'h5, 8'h7F, 8'h80, 4'h5, 3);
    rdc(8'h10, 32'h0);
    run(5'h0E, 8'h7, 8'h80, 8'hAA, 4'h5, 8'h80, 8'hAA, 4'h5, 4);
    run(5'h0E, 8'h6, 8'hBF, 8'hAA, 4'h5, 8'hBF, 8'hAA, 4'h5, 3);
    run(5'h16, 8'h6, 8'hBF, 8'hAA, 4'h5, 8'hBF, 8'hAA, 4'h5, 4);
    run(5'h14, 8'h0, 8'h01, 8'hAA, 4'h5, 8'h01, 8'hAA, 4'h5, 3);
    run(5'h14, 8'h0, 8'h00, 8'hAA, 4'h5, 8'h00, 8'hAA, 4'h5, 4);
    run(5'h15, 8'h0, 8'h00, 8'hAA, 4'h5, 8'h00, 8'h00, 4'h5, 4);
    rdc(8'h10, 32'h2);
  endtask
  task t_set;
    run(5'h0C, 8'h0, 8'h12, 8'hAA, 4'hA, 8'hFF, 8'hAA, 4'hA, 3);
    run(5'h0D, 8'h6, 8'h81, 8'hAA, 4'hA, 8'hC1, 8'hAA, 4'hA, 3);
    run(5'h12, 8'h0, 8'h3C, 8'hAA, 4'hA, 8'hC3, 8'hAA, 4'hA, 3);
    run(5'h13, 8'h0, 8'h5E, 8'hAA, 4'hA, 8'h5E, 8'hE5, 4'hA, 3);
  endtask
  task t_xor;
    run(5'h19, 8'h0, 8'h5A, 8'h5A, 4'hB, 8'h5A, 8'h00, 4'hF, 3);
    run(5'h1A, 8'h0, 8'h0F, 8'h5A, 4'hF, 8'h55, 8'h5A, 4'hB, 3);
    run(5'h1B, 8'hFF, 8'h00, 8'h5A, 4'h4, 8'h00, 8'hA5, 4'h0, 3);
  endtask
  task t_tab;
    wr(8'h08, 32'h3C);
    page <= 3'h2;
    run(5'h17, 8'h0, 8'h00, 8'hAA, 4'h5, 8'hC3, 8'hAA, 4'h5, 3);
    rdc(8'h0C, 32'h12);
    page <= 3'h5;
    run(5'h18, 8'h0, 8'h00, 8'hAA, 4'h5, 8'hC3, 8'hAA, 4'h5, 3);
    rdc(8'h0C, 32'h3F);
  endtask

  // main sequence
  initial begin
    {rst, hsel, hwrite, ost, htrans, haddr, hwdata} = {4'h8, 66'h0};
    {code, oad, obit, imm, page} = 26'h0;
    miscompares = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_rot;
    t_sub;
    t_skip;
    t_set;
    t_xor;
    t_tab;
    give_verdict;
  end
  // watchdog
  initial begin
    repeat (8000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule // tb_top
